//--- pkg/cfwd_pkg.sv
// package for the configuration bytes and watchdog block
package cfwd_pkg;
  // printed register indices
  localparam logic [23:0] CFWD_IDX_OSC     = 24'h30_0002;
  localparam logic [23:0] CFWD_IDX_DOGPS   = 24'h30_0003;
  localparam logic [23:0] CFWD_IDX_EXTBUS  = 24'h30_0004;
  localparam logic [23:0] CFWD_IDX_PINPL   = 24'h30_0005;
  // byte addresses: four times the low index nibble
  localparam logic [7:0]  CFWD_A_OSC       = 8'h08;
  localparam logic [7:0]  CFWD_A_DOGPS     = 8'h0C;
  localparam logic [7:0]  CFWD_A_EXTBUS    = 8'h10;
  localparam logic [7:0]  CFWD_A_PINPL     = 8'h14;
  localparam logic [7:0]  CFWD_A_IDLO      = 8'h20;
  localparam logic [7:0]  CFWD_A_IDHI      = 8'h24;
  localparam logic [7:0]  CFWD_A_DOGCTL    = 8'h28;
  localparam logic [7:0]  CFWD_A_DOGCMD    = 8'h2C;
  localparam logic [7:0]  CFWD_A_DOGSTAT   = 8'h30;
  // implemented bit masks of the config bytes
  localparam logic [7:0]  CFWD_M_OSC       = 8'hC7;
  localparam logic [7:0]  CFWD_M_DOGPS     = 8'h0F;
  localparam logic [7:0]  CFWD_M_EXTBUS    = 8'hF8;
  localparam logic [7:0]  CFWD_M_PINPL     = 8'h0F;
  // field positions
  localparam int CFWD_B_TWOSPD  = 7;
  localparam int CFWD_B_FCM     = 6;
  localparam int CFWD_B_WAIT    = 7;
  localparam int CFWD_B_BW      = 6;
  localparam int CFWD_B_EMB     = 4;
  localparam int CFWD_B_SHIFT   = 3;
  localparam int CFWD_B_MASK    = 3;
  localparam int CFWD_B_PMP     = 2;
  localparam int CFWD_B_ECCP    = 1;
  localparam int CFWD_B_CAP2    = 0;
  localparam int CFWD_B_SOFTEN  = 0;
  localparam int CFWD_B_CFGEN   = 1;
  localparam int CFWD_B_VSTAT   = 6;
  // command bits
  localparam int CFWD_B_CLR     = 0;
  localparam int CFWD_B_SLEEP   = 1;
  // timing
  localparam int CFWD_CLK_MHZ   = 250;
  localparam int CFWD_BASE_MS   = 4;
  localparam int CFWD_BASE_CYC  = CFWD_BASE_MS * 1000 * CFWD_CLK_MHZ * 1000 / 1000;
  localparam int CFWD_PS_W      = 16;
  // axi responses
  localparam logic [1:0] CFWD_RESP_OK  = 2'b00;
  localparam logic [1:0] CFWD_RESP_ERR = 2'b10;
  // oscillator select codes
  typedef enum logic [2:0] {
    CFWD_OSC_INT      = 3'b000,
    CFWD_OSC_INT_CKO  = 3'b001,
    CFWD_OSC_INT_PLL  = 3'b010,
    CFWD_OSC_INTP_CKO = 3'b011,
    CFWD_OSC_XTAL     = 3'b100,
    CFWD_OSC_XTAL_PLL = 3'b101,
    CFWD_OSC_EXT      = 3'b110,
    CFWD_OSC_EXT_PLL  = 3'b111
  } cfwd_osc_e;
  // clock decode outputs
  typedef struct packed {
    logic use_internal;
    logic use_pll;
    logic clock_out_pin;
    logic usb_from_primary;
    logic two_speed_startup_en;
    logic clock_monitor_en;
  } cfwd_clk_s;
  // external bus and pin placement decode
  typedef struct packed {
    logic       ext_bus_on;
    logic [4:0] ext_addr_width;
    logic       wait_states_en;
    logic       bus_width_sel;
    logic       ext_addr_shift_en;
    logic       serial_addr_mask_mode;
    logic       parallel_port_placement;
    logic       capture_outputs_placement;
    logic [1:0] capture2_pin;
  } cfwd_bus_s;
  // capture 2 pin choices
  localparam logic [1:0] CFWD_CAP2_PC1 = 2'b00;
  localparam logic [1:0] CFWD_CAP2_PE7 = 2'b01;
  localparam logic [1:0] CFWD_CAP2_PB3 = 2'b10;
  // address widths
  localparam logic [4:0] CFWD_AW_12 = 5'd12;
  localparam logic [4:0] CFWD_AW_16 = 5'd16;
  localparam logic [4:0] CFWD_AW_20 = 5'd20;
  localparam logic [4:0] CFWD_AW_0  = 5'd0;
endpackage

//--- rtl/cfwd_top.sv
// configuration bytes, part identification and watchdog with axi4-lite slave
// Operation
// - config bits readable, write-once per power cycle, one after power-on reset
// - oscillator byte bit 7 enables two-speed start-up
// - oscillator byte bit 6 enables fail-safe clock monitor
// - codes 111..100 pick external clock or crystal, with or without pll
// - codes 011..000 pick internal oscillator; pll and clock-out per code
// - postscale field gives divide ratio two to the field value
// - wait bit 1 disables bus wait states, 0 enables them
// - bus width bit selects 16-bit when 1, 8-bit when 0
// - bus field 11 no bus; 10/01/00 give 12/16/20 address bits
// - address shift bit offsets external address bus to zero
// - pin byte bit 3 selects 7-bit or 5-bit serial address masking
// - pin byte bit 2 places parallel port pins on external bus
// - pin byte bit 1 routes capture outputs to port E or port H
// - pin byte bit 0 routes capture 2 to C1, else E7 or B3
// - low id byte holds part code bits 7:5 and revision 4:0, read-only
// - watchdog runs on internal rc oscillator, enabling it enables the oscillator
// - watchdog base period is nominally 4 ms
// - base period drives 16-bit postscaler, tap picked by postscale field
// - sleep, clear instruction or oscillator failure clear counter and postscaler
// - software enable matters only when configuration enable is off
// - core-voltage status is read-only and continuously updated
// - configuration enable 1 forces watchdog on, else software bit decides
// - software enable is control bit 0, resets to 0
//
// Local design decision: register access over AXI4-Lite.
module cfwd_top
  import cfwd_pkg::*;
#(
  parameter int          BASE_CYC = CFWD_BASE_CYC,
  parameter logic [7:0]  PART_HI  = 8'h5A, // arbitrary identification value
  parameter logic [2:0]  PART_LO  = 3'b011, // arbitrary identification value
  parameter logic [4:0]  REVISION = 5'h01   // arbitrary identification value
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_n,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core events and status pins
  input  wire logic        config_dog_enable,
  input  wire logic        osc_fail,
  input  wire logic        core_voltage_ok,
  input  wire logic        cpu_sleeping,
  // decoded configuration
  output cfwd_clk_s        clk_cfg,
  output cfwd_bus_s        bus_cfg,
  output logic [2:0]       osc_select,
  output logic [3:0]       dog_postscale_sel,
  // watchdog outputs
  output logic             internal_rc_osc_en,
  output logic             dog_reset,
  output logic             dog_wake
);

  // config bytes and their written flags, restored only by power-on reset
  logic [7:0] osc_reg, dogps_reg, extbus_reg, pinpl_reg;
  logic [7:0] osc_wr_reg, dogps_wr_reg, extbus_wr_reg, pinpl_wr_reg;
  logic       soft_en_reg, timeout_flag_reg;
  logic [1:0] fail_sync_reg, cfgen_sync_reg, vstat_sync_reg, sleep_sync_reg;
  logic [31:0] base_cnt_reg;
  logic [CFWD_PS_W:0] ps_cnt_reg;
  logic       aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       clr_pulse_reg, sleep_cmd_reg;

  // bus write: capture address and data in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire [7:0] wr_byte = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  wire wr_lane = w_strb_reg[0];
  wire wr_osc    = wr_go && wr_lane && aw_addr_reg == CFWD_A_OSC;
  wire wr_dogps  = wr_go && wr_lane && aw_addr_reg == CFWD_A_DOGPS;
  wire wr_extbus = wr_go && wr_lane && aw_addr_reg == CFWD_A_EXTBUS;
  wire wr_pinpl  = wr_go && wr_lane && aw_addr_reg == CFWD_A_PINPL;
  wire wr_ctl    = wr_go && wr_lane && aw_addr_reg == CFWD_A_DOGCTL;
  wire wr_cmd    = wr_go && wr_lane && aw_addr_reg == CFWD_A_DOGCMD;
  wire wr_stat   = wr_go && wr_lane && aw_addr_reg == CFWD_A_DOGSTAT;
  wire wr_known  = aw_addr_reg == CFWD_A_OSC || aw_addr_reg == CFWD_A_DOGPS ||
                   aw_addr_reg == CFWD_A_EXTBUS || aw_addr_reg == CFWD_A_PINPL ||
                   aw_addr_reg == CFWD_A_IDLO || aw_addr_reg == CFWD_A_IDHI ||
                   aw_addr_reg == CFWD_A_DOGCTL || aw_addr_reg == CFWD_A_DOGCMD ||
                   aw_addr_reg == CFWD_A_DOGSTAT;

  // write-once merge: unwritten bits only
  function automatic logic [7:0] once_val(input logic [7:0] cur, input logic [7:0] wr,
                                          input logic [7:0] d, input logic [7:0] m);
    once_val = (cur & (wr | ~m)) | (d & ~wr & m);
  endfunction

  // config bytes: held across warm resets, ones after power-on
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      osc_reg       <= CFWD_M_OSC;
      dogps_reg     <= CFWD_M_DOGPS;
      extbus_reg    <= CFWD_M_EXTBUS;
      pinpl_reg     <= CFWD_M_PINPL;
      osc_wr_reg    <= 8'h00;
      dogps_wr_reg  <= 8'h00;
      extbus_wr_reg <= 8'h00;
      pinpl_wr_reg  <= 8'h00;
    end else begin
      if (wr_osc) begin
        osc_reg    <= once_val(osc_reg, osc_wr_reg, wr_byte, CFWD_M_OSC);
        osc_wr_reg <= osc_wr_reg | CFWD_M_OSC;
      end
      if (wr_dogps) begin
        dogps_reg    <= once_val(dogps_reg, dogps_wr_reg, wr_byte, CFWD_M_DOGPS);
        dogps_wr_reg <= dogps_wr_reg | CFWD_M_DOGPS;
      end
      if (wr_extbus) begin
        extbus_reg    <= once_val(extbus_reg, extbus_wr_reg, wr_byte, CFWD_M_EXTBUS);
        extbus_wr_reg <= extbus_wr_reg | CFWD_M_EXTBUS;
      end
      if (wr_pinpl) begin
        pinpl_reg    <= once_val(pinpl_reg, pinpl_wr_reg, wr_byte, CFWD_M_PINPL);
        pinpl_wr_reg <= pinpl_wr_reg | CFWD_M_PINPL;
      end
    end
  end

  // write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CFWD_RESP_OK;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? CFWD_RESP_OK : CFWD_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready only while the holding slot is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !aw_take && !s_axi_awready;
      s_axi_wready  <= !w_hold_reg && !w_take && !s_axi_wready;
    end
  end

  // two-flop synchronisers for pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_sync_reg  <= 2'b00;
      cfgen_sync_reg <= 2'b00;
      vstat_sync_reg <= 2'b00;
      sleep_sync_reg <= 2'b00;
    end else begin
      fail_sync_reg  <= {fail_sync_reg[0], osc_fail};
      cfgen_sync_reg <= {cfgen_sync_reg[0], config_dog_enable};
      vstat_sync_reg <= {vstat_sync_reg[0], core_voltage_ok};
      sleep_sync_reg <= {sleep_sync_reg[0], cpu_sleeping};
    end
  end

  // software enable and commands; expiry closes the last of 2^sel base periods
  wire dog_on    = cfgen_sync_reg[1] | soft_en_reg;
  wire base_tick = base_cnt_reg == 32'(BASE_CYC - 1);
  wire [CFWD_PS_W:0] ps_top = {{CFWD_PS_W{1'b0}}, 1'b1} << dog_postscale_sel;
  wire ps_expire = base_tick && ps_cnt_reg + 1'b1 == ps_top;
  wire dog_clear = clr_pulse_reg | sleep_cmd_reg | fail_sync_reg[1] | !dog_on;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_en_reg      <= 1'b0;
      clr_pulse_reg    <= 1'b0;
      sleep_cmd_reg    <= 1'b0;
    end else begin
      if (wr_ctl) soft_en_reg <= wr_byte[CFWD_B_SOFTEN];
      clr_pulse_reg <= wr_cmd && wr_byte[CFWD_B_CLR];
      sleep_cmd_reg <= wr_cmd && wr_byte[CFWD_B_SLEEP];
    end
  end

  // time-out flag survives warm reset; set wins over software clear
  always_ff @(posedge aclk) begin
    if (!por_n) timeout_flag_reg <= 1'b0;
    else if (ps_expire && dog_on) timeout_flag_reg <= 1'b1;
    else if (wr_stat && wr_byte[CFWD_B_CLR]) timeout_flag_reg <= 1'b0;
  end

  // base period counter and postscaler
  always_ff @(posedge aclk) begin
    if (!aresetn || dog_clear || ps_expire) begin
      base_cnt_reg <= 32'h0000_0000;
      ps_cnt_reg   <= '0;
    end else if (base_tick) begin
      base_cnt_reg <= 32'h0000_0000;
      ps_cnt_reg   <= ps_cnt_reg + 1'b1;
    end else begin
      base_cnt_reg <= base_cnt_reg + 32'h0000_0001;
    end
  end

  // time-out outputs: reset when awake, wake when sleeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dog_reset          <= 1'b0;
      dog_wake           <= 1'b0;
      internal_rc_osc_en <= 1'b0;
    end else begin
      dog_reset          <= ps_expire && dog_on && !sleep_sync_reg[1];
      dog_wake           <= ps_expire && dog_on && sleep_sync_reg[1];
      internal_rc_osc_en <= dog_on;
    end
  end

  // decode of the configuration fields
  wire [2:0] osc_code = osc_reg[2:0];
  wire [1:0] emb      = extbus_reg[CFWD_B_EMB +: 2];
  wire       ext_on   = emb != 2'b11;
  cfwd_clk_s clk_next;
  cfwd_bus_s bus_next;
  assign clk_next.two_speed_startup_en = osc_reg[CFWD_B_TWOSPD];
  assign clk_next.clock_monitor_en     = osc_reg[CFWD_B_FCM];
  assign clk_next.use_internal         = !osc_code[2];
  assign clk_next.use_pll              = osc_code == CFWD_OSC_EXT_PLL ||
                                         osc_code == CFWD_OSC_XTAL_PLL ||
                                         osc_code == CFWD_OSC_INTP_CKO ||
                                         osc_code == CFWD_OSC_INT_PLL;
  assign clk_next.clock_out_pin        = osc_code == CFWD_OSC_EXT_PLL ||
                                         osc_code == CFWD_OSC_EXT ||
                                         osc_code == CFWD_OSC_INTP_CKO ||
                                         osc_code == CFWD_OSC_INT_CKO;
  assign clk_next.usb_from_primary     = osc_code[2];
  assign bus_next.ext_bus_on           = ext_on;
  assign bus_next.ext_addr_width       = emb == 2'b10 ? CFWD_AW_12 :
                                         emb == 2'b01 ? CFWD_AW_16 :
                                         emb == 2'b00 ? CFWD_AW_20 : CFWD_AW_0;
  assign bus_next.wait_states_en       = !extbus_reg[CFWD_B_WAIT];
  assign bus_next.bus_width_sel        = extbus_reg[CFWD_B_BW];
  assign bus_next.ext_addr_shift_en    = extbus_reg[CFWD_B_SHIFT];
  assign bus_next.serial_addr_mask_mode = pinpl_reg[CFWD_B_MASK];
  assign bus_next.parallel_port_placement = pinpl_reg[CFWD_B_PMP];
  assign bus_next.capture_outputs_placement = pinpl_reg[CFWD_B_ECCP];
  assign bus_next.capture2_pin         = pinpl_reg[CFWD_B_CAP2] ? CFWD_CAP2_PC1 :
                                         ext_on ? CFWD_CAP2_PB3 : CFWD_CAP2_PE7;

  // registered decode outputs
  always_ff @(posedge aclk) begin
    clk_cfg           <= clk_next;
    bus_cfg           <= bus_next;
    osc_select        <= osc_code;
    dog_postscale_sel <= dogps_reg[3:0];
  end

  // read decode
  wire [7:0] dog_ctl_rd = {1'b0, vstat_sync_reg[1], 5'b0_0000, soft_en_reg};
  wire [7:0] dog_st_rd  = {6'b00_0000, cfgen_sync_reg[1], timeout_flag_reg};
  wire [7:0] rd_a = {s_axi_araddr[7:2], 2'b00};
  wire [7:0] rd_byte =
    rd_a == CFWD_A_OSC     ? osc_reg :
    rd_a == CFWD_A_DOGPS   ? dogps_reg :
    rd_a == CFWD_A_EXTBUS  ? extbus_reg :
    rd_a == CFWD_A_PINPL   ? pinpl_reg :
    rd_a == CFWD_A_IDLO    ? {PART_LO, REVISION} :
    rd_a == CFWD_A_IDHI    ? PART_HI :
    rd_a == CFWD_A_DOGCTL  ? dog_ctl_rd :
    rd_a == CFWD_A_DOGSTAT ? dog_st_rd : 8'h00;
  wire rd_known = rd_a == CFWD_A_OSC || rd_a == CFWD_A_DOGPS || rd_a == CFWD_A_EXTBUS ||
                  rd_a == CFWD_A_PINPL || rd_a == CFWD_A_IDLO || rd_a == CFWD_A_IDHI ||
                  rd_a == CFWD_A_DOGCTL || rd_a == CFWD_A_DOGCMD ||
                  rd_a == CFWD_A_DOGSTAT;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CFWD_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_known ? CFWD_RESP_OK : CFWD_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- test/cfwd_top_assertions.sv
// port checks for the configuration bytes and watchdog block
module cfwd_top_chk
  import cfwd_pkg::*;
#(
  parameter logic [7:0] PART_HI  = 8'h00,
  parameter logic [2:0] PART_LO  = 3'h0,
  parameter logic [4:0] REVISION = 5'h00
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // read channel
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // pins and decoded configuration
  input wire logic        config_dog_enable,
  input wire cfwd_clk_s   clk_cfg,
  input wire cfwd_bus_s   bus_cfg,
  input wire logic [2:0]  osc_select,
  input wire logic [3:0]  dog_postscale_sel,
  // watchdog outputs
  input wire logic        internal_rc_osc_en,
  input wire logic        dog_reset,
  input wire logic        dog_wake
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // read taken, and whether its address is decoded
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire ar_map  = s_axi_araddr inside {CFWD_A_OSC, CFWD_A_DOGPS, CFWD_A_EXTBUS, CFWD_A_PINPL,
                 CFWD_A_IDLO, CFWD_A_IDHI, CFWD_A_DOGCTL, CFWD_A_DOGCMD, CFWD_A_DOGSTAT};
  // expiry pulses
  chk_pulse_single: assert property (dog_reset |=> !dog_reset)
    else $error("long reset pulse");
  chk_wake_excl: assert property (!(dog_reset && dog_wake))
    else $error("wake with reset");
  chk_off_quiet: assert property (!internal_rc_osc_en [*2] |-> !dog_reset && !dog_wake)
    else $error("expiry while off");
  chk_cfg_forces: assert property (config_dog_enable [*6] |-> internal_rc_osc_en)
    else $error("forced enable ignored");
  // decode follows the stored fields
  chk_osc_decode: assert property ($stable(osc_select) |->
    clk_cfg.use_internal == !osc_select[2] && clk_cfg.usb_from_primary == osc_select[2] &&
    clk_cfg.use_pll == (osc_select inside {3'h7, 3'h5, 3'h3, 3'h2}) &&
    clk_cfg.clock_out_pin == (osc_select inside {3'h7, 3'h6, 3'h3, 3'h1}))
    else $error("osc decode");
  chk_bus_width: assert property (bus_cfg.ext_bus_on == |bus_cfg.ext_addr_width)
    else $error("bus width decode");
  chk_cap2_mode: assert property (bus_cfg.capture2_pin != CFWD_CAP2_PC1 |->
    (bus_cfg.capture2_pin == CFWD_CAP2_PB3) == bus_cfg.ext_bus_on)
    else $error("capture 2 pin");
  // reads answer one edge after the address is taken
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("late read");
  chk_id_low: assert property (ar_take && s_axi_araddr == CFWD_A_IDLO |=>
    s_axi_rdata == {24'h00_0000, PART_LO, REVISION})
    else $error("id low");
  chk_id_high: assert property (ar_take && s_axi_araddr == CFWD_A_IDHI |=>
    s_axi_rdata == {24'h00_0000, PART_HI})
    else $error("id high");
  chk_ps_read: assert property (ar_take && s_axi_araddr == CFWD_A_DOGPS |=>
    s_axi_rdata == {28'h000_0000, dog_postscale_sel})
    else $error("postscale read");
  chk_unmapped: assert property (ar_take && !ar_map |=>
    s_axi_rresp == CFWD_RESP_ERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read");
endmodule

//--- test/cfwd_top_tb_top.sv
// bench for the configuration bytes and watchdog block
module cfwd_top_tb_top
  import cfwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         BASE = 4;
  localparam logic [7:0] HI   = 8'hA5; // arbitrary identification value
  localparam logic [2:0] LO   = 3'h6;  // arbitrary identification value
  localparam logic [4:0] REV  = 5'h0B; // arbitrary identification value
  // bench signals
  logic        aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        cfg_en = 1'h0, osc_fail = 1'h0, v_ok = 1'h0, sleeping = 1'h0;
  cfwd_clk_s   clk_cfg;
  cfwd_bus_s   bus_cfg;
  logic [2:0]  osc_select;
  logic [3:0]  ps_sel;
  logic        rc_en, dog_reset, dog_wake;
  int          n_mismatch = 0, checks = 0, n_rst = 0, n_wake = 0;
  always #2 aclk = ~aclk;
  cfwd_top #(.BASE_CYC(BASE), .PART_HI(HI), .PART_LO(LO), .REVISION(REV)) i_cfwd_top (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .config_dog_enable(cfg_en), .osc_fail(osc_fail), .core_voltage_ok(v_ok),
    .cpu_sleeping(sleeping), .clk_cfg(clk_cfg), .bus_cfg(bus_cfg), .osc_select(osc_select),
    .dog_postscale_sel(ps_sel), .internal_rc_osc_en(rc_en), .dog_reset(dog_reset),
    .dog_wake(dog_wake));
  // pulse counters, sampled mid-cycle
  always @(negedge aclk) begin
    if (dog_reset === 1'h1) n_rst++;
    if (dog_wake === 1'h1) n_wake++;
  end
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    chk("write answer", {bvalid, bresp}, {1'h1, CFWD_RESP_OK});
  endtask
  // bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    d = rdata;
    r = rvalid ? rresp : 2'h3;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, {r, d}, {CFWD_RESP_OK, exp});
  endtask
  task automatic power_on;
    @(posedge aclk);
    aresetn <= 1'h0;
    por_n <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    por_n <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask
  // cycles until the next reset pulse
  task automatic wait_rst(output int n);
    for (n = 1; n < 3000; n++) begin
      @(posedge aclk);
      if (dog_reset === 1'h1) break;
    end
  endtask
  // reset values, read-only bits, unmapped address
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rdchk("osc byte", CFWD_A_OSC, 32'h0000_00C7);
    rdchk("postscale byte", CFWD_A_DOGPS, 32'h0000_000F);
    rdchk("bus byte", CFWD_A_EXTBUS, 32'h0000_00F8);
    rdchk("pin byte", CFWD_A_PINPL, 32'h0000_000F);
    wr(CFWD_A_IDLO, 32'h0000_0000);
    wr(CFWD_A_IDHI, 32'h0000_0000);
    rdchk("id low", CFWD_A_IDLO, {24'h00_0000, LO, REV});
    rdchk("id high", CFWD_A_IDHI, {24'h00_0000, HI});
    v_ok <= 1'h1;
    wr(CFWD_A_DOGCTL, 32'h0000_0000);
    rdchk("control", CFWD_A_DOGCTL, 32'h0000_0040);
    v_ok <= 1'h0;
    wr(CFWD_A_DOGCTL, 32'h0000_0040);
    rdchk("control", CFWD_A_DOGCTL, 32'h0000_0000);
    rd(8'h3C, d, r);
    chk("unmapped read", {r, d}, {CFWD_RESP_ERR, 32'h0000_0000});
  endtask
  // every oscillator code, each after a fresh power-on
  task automatic t_osc;
    logic [2:0] c;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      v = {i[0], ~i[0], 3'h0, c};
      power_on();
      wr(CFWD_A_OSC, {24'h00_0000, v});
      wr(CFWD_A_OSC, 32'h0000_00FF);
      repeat (3) @(posedge aclk);
      rdchk("osc byte once", CFWD_A_OSC, {24'h00_0000, v});
      chk("osc select", osc_select, c);
      chk("osc decode", clk_cfg, {~c[2], (c inside {3'h7, 3'h5, 3'h3, 3'h2}),
          (c inside {3'h7, 3'h6, 3'h3, 3'h1}), c[2], v[7], v[6]});
    end
  endtask
  // every bus mode and pin placement
  task automatic t_bus;
    logic [1:0] e, cap;
    logic [7:0] xb, pp;
    logic [4:0] w;
    for (int i = 0; i < 4; i++) begin
      e = i[1:0];
      xb = {i[0], i[1], e, i[0] ^ i[1], 3'h0};
      pp = {4'h0, i[0], ~i[0], i[1], i == 1};
      w = e == 2'h2 ? CFWD_AW_12 : e == 2'h1 ? CFWD_AW_16 : e == 2'h0 ? CFWD_AW_20 : CFWD_AW_0;
      cap = (i == 1) ? CFWD_CAP2_PC1 : (e == 2'h3) ? CFWD_CAP2_PE7 : CFWD_CAP2_PB3;
      power_on();
      wr(CFWD_A_EXTBUS, {24'h00_0000, xb});
      wr(CFWD_A_PINPL, {24'h00_0000, pp});
      repeat (3) @(posedge aclk);
      chk("bus decode", bus_cfg,
          {e != 2'h3, w, ~xb[7], xb[6], xb[3], pp[3], pp[2], pp[1], cap});
    end
  endtask
  // watchdog period, clears, wake, enables and flag
  task automatic t_dog;
    int n, s, sr;
    power_on();
    wr(CFWD_A_DOGPS, 32'h0000_0002);
    chk("dog off at reset", rc_en, 1'h0);
    wr(CFWD_A_DOGCTL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("rc osc on", rc_en, 1'h1);
    wait_rst(n);
    wait_rst(n);
    chk("period", n, 4 * BASE);
    s = n_rst;
    for (int j = 0; j < 12; j++) wr(CFWD_A_DOGCMD, j[0] ? 32'h0000_0002 : 32'h0000_0001);
    chk("cleared dog", n_rst - s, 0);
    sleeping <= 1'h1;
    repeat (4) @(posedge aclk);
    s = n_wake;
    sr = n_rst;
    repeat (20) @(posedge aclk);
    chk("woken", {n_wake != s, n_rst - sr}, {1'h1, 32'h0000_0000});
    sleeping <= 1'h0;
    osc_fail <= 1'h1;
    repeat (4) @(posedge aclk);
    s = n_rst + n_wake;
    repeat (40) @(posedge aclk);
    chk("frozen by clock failure", n_rst + n_wake - s, 0);
    osc_fail <= 1'h0;
    wr(CFWD_A_DOGCTL, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("rc osc off", rc_en, 1'h0);
    s = n_rst;
    repeat (40) @(posedge aclk);
    chk("stopped dog", n_rst - s, 0);
    rdchk("flag set", CFWD_A_DOGSTAT, 32'h0000_0001);
    wr(CFWD_A_DOGSTAT, 32'h0000_0001);
    rdchk("flag cleared", CFWD_A_DOGSTAT, 32'h0000_0000);
    cfg_en <= 1'h1;
    repeat (6) @(posedge aclk);
    chk("forced on", rc_en, 1'h1);
    wait_rst(n);
    chk("forced expiry", n < 40, 1'h1);
    cfg_en <= 1'h0;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    por_n <= 1'h1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_osc();
    t_bus();
    t_dog();
    tally_and_finish();
  end
endmodule
bind cfwd_top cfwd_top_chk #(.PART_HI(PART_HI), .PART_LO(PART_LO), .REVISION(REVISION))
  i_cfwd_top_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .config_dog_enable(config_dog_enable),
  .clk_cfg(clk_cfg), .bus_cfg(bus_cfg), .osc_select(osc_select),
  .dog_postscale_sel(dog_postscale_sel), .internal_rc_osc_en(internal_rc_osc_en),
  .dog_reset(dog_reset), .dog_wake(dog_wake));
